// ===== hdl/ckgs_consts.vh
// constants for the clock generator status, ident and drive-strength bytes
// assumes: included by the design files by bare name, no other setup needed
`ifndef CKGS_CONSTS_VH
`define CKGS_CONSTS_VH

// byte offsets on the serial management bus
`define CKGS_OFS_REF_MID        5'h03
`define CKGS_OFS_MULTIPLIER     5'h08
`define CKGS_OFS_DIVIDER        5'h09
`define CKGS_OFS_SEL_STATUS     5'h0A
`define CKGS_OFS_MAKER_REV      5'h0B
`define CKGS_OFS_PART_IDENT     5'h0C
`define CKGS_OFS_SPARE_A        5'h0D
`define CKGS_OFS_SPARE_B        5'h0E
`define CKGS_OFS_LENGTH_COUNT   5'h0F
`define CKGS_OFS_DRIVE_STRENGTH 5'h10

// field positions
`define CKGS_BIT_REF_MID        4
`define CKGS_BIT_REF_MSB        7
`define CKGS_BIT_REF_LSB        6
`define CKGS_BIT_FSEL_B         7
`define CKGS_BIT_FSEL_C         6
`define CKGS_BIT_PCIE0_EN       5
`define CKGS_BIT_PCIE2_EN       3
`define CKGS_BIT_CMD_BYTE_MODE  7

// reset values
`define CKGS_RST_LENGTH_COUNT   8'h16
`define CKGS_RST_REF_MSB        1'b0
`define CKGS_RST_REF_MID        1'b1
`define CKGS_RST_REF_LSB        1'b1
`define CKGS_RST_SPARE          8'h00

// bus constants
`define CKGS_SMB_ADDR_DEF       7'h69
`define CKGS_BITS_PER_BYTE      4'h8
`define CKGS_ACK_SLOT           4'h9

`endif

// ===== hdl/ckgs_sync.v
// two-flop level synchroniser, one stage pair per bit
// assumes: inputs are asynchronous pins, outputs are read in i_mclk domain
`timescale 1ns/1ps
`default_nettype none

module ckgs_sync #(
  parameter WIDTH = 7
) (
  // clock and reset
  input  wire             i_mclk,
  input  wire             i_reset,
  // pins in, synchronised levels out
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      // first stage feeds only the second stage
      always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
        end else begin
          meta_q <= i_async[g];
          sync_q <= meta_q;
        end
      end
      assign o_sync[g] = sync_q;
    end
  endgenerate

endmodule // ckgs_sync

`default_nettype wire

// ===== hdl/ckgs_shreg.v
// msb-first shift register with parallel load, used for serial rx and tx
// assumes: load and shift are single-cycle enables from the same clock
`timescale 1ns/1ps
`default_nettype none

module ckgs_shreg #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             i_mclk,
  input  wire             i_reset,
  // control
  input  wire             i_load,
  input  wire [WIDTH-1:0] i_load_val,
  input  wire             i_shift,
  input  wire             i_shift_in,
  // contents
  output reg  [WIDTH-1:0] o_value
);

  // load wins over shift so a byte boundary never loses its new value
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_value <= {WIDTH{1'b0}};
    end else if (i_load) begin
      o_value <= i_load_val;
    end else if (i_shift) begin
      o_value <= {o_value[WIDTH-2:0], i_shift_in};
    end
  end

endmodule // ckgs_shreg

`default_nettype wire

// ===== hdl/ckgs_status_regs.v
// status, ident, byte-count and reference drive-strength bytes of the
// clock generator, reached through the serial management slave pins
// assumes: bus pins are asynchronous; loop values come from i_mclk logic
`timescale 1ns/1ps
`default_nettype none
`include "ckgs_consts.vh"

module ckgs_status_regs #(
  parameter [6:0] SMB_ADDR  = `CKGS_SMB_ADDR_DEF,
  parameter [3:0] MAKER_ID  = 4'h5, // arbitrary value
  parameter [3:0] REV_CODE  = 4'h3, // arbitrary value
  parameter [3:0] PART_CODE = 4'h6  // arbitrary value
) (
  // clock and reset
  input  wire       i_mclk,
  input  wire       i_reset,
  // serial management bus pins (open drain)
  input  wire       i_smb_clk,
  input  wire       i_smb_data,
  output reg        o_smb_data,
  output reg        o_smb_data_oe,
  // hardware loop values
  input  wire [7:0] i_third_loop_multiplier,
  input  wire [7:0] i_third_loop_divider,
  // status pins
  input  wire       i_freq_select_b,
  input  wire       i_freq_select_c,
  input  wire [2:0] i_pcie_enable_n,
  // control outputs
  output reg  [2:0] o_ref_drive_code,
  output reg  [7:0] o_transfer_length_count
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_CMD   = 3'h2;
  localparam [2:0] ST_WCNT  = 3'h3;
  localparam [2:0] ST_WDATA = 3'h4;
  localparam [2:0] ST_RDATA = 3'h5;
  localparam [2:0] ST_SKIP  = 3'h6;

  // pin synchronisers
  wire [6:0] pin_sync;
  wire       scl_s;
  wire       sda_s;
  wire       fsel_b_s;
  wire       fsel_c_s;
  wire [2:0] pcie_en_n_s;

  ckgs_sync #(
    .WIDTH (7)
  ) u_sync (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_async ({i_smb_clk, i_smb_data, i_freq_select_b, i_freq_select_c,
               i_pcie_enable_n}),
    .o_sync  (pin_sync)
  );

  assign scl_s       = pin_sync[6];
  assign sda_s       = pin_sync[5];
  assign fsel_b_s    = pin_sync[4];
  assign fsel_c_s    = pin_sync[3];
  assign pcie_en_n_s = pin_sync[2:0];

  // bus events
  reg        scl_prev_q;
  reg        sda_prev_q;
  wire       scl_rise;
  wire       scl_fall;
  wire       bus_start;
  wire       bus_stop;

  assign scl_rise  = scl_s & ~scl_prev_q;
  assign scl_fall  = ~scl_s & scl_prev_q;
  assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign bus_stop  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // register state
  reg  [7:0] sel_status_q;
  reg        ref_mid_q;
  reg        ref_msb_q;
  reg        ref_lsb_q;
  reg  [7:0] length_count_q;

  // slave state
  reg  [2:0] state_q;
  reg  [2:0] state_d;
  reg  [3:0] bitcnt_q;
  reg  [3:0] bitcnt_d;
  reg  [4:0] ptr_q;
  reg  [4:0] ptr_d;
  reg        rw_q;
  reg        rw_d;
  reg        block_q;
  reg        block_d;
  reg        nack_q;
  reg        nack_d;
  reg        oe_d;
  reg        wr_en;
  reg        tx_load;
  reg        tx_shift;
  reg  [7:0] tx_load_val;
  reg  [7:0] rd_data;
  wire [7:0] rx_byte;
  wire [7:0] tx_byte;
  wire       rx_state;

  assign rx_state = (state_q == ST_ADDR) | (state_q == ST_CMD) |
                    (state_q == ST_WCNT) | (state_q == ST_WDATA);

  ckgs_shreg #(
    .WIDTH (8)
  ) u_rx (
    .i_mclk     (i_mclk),
    .i_reset    (i_reset),
    .i_load     (1'b0),
    .i_load_val (8'h00),
    .i_shift    (scl_rise & rx_state & (bitcnt_q < `CKGS_BITS_PER_BYTE)),
    .i_shift_in (sda_s),
    .o_value    (rx_byte)
  );

  ckgs_shreg #(
    .WIDTH (8)
  ) u_tx (
    .i_mclk     (i_mclk),
    .i_reset    (i_reset),
    .i_load     (tx_load),
    .i_load_val (tx_load_val),
    .i_shift    (tx_shift),
    .i_shift_in (1'b0),
    .o_value    (tx_byte)
  );

  // read data for the current pointer; unmapped bytes read zero
  always @* begin
    rd_data = 8'h00;
    case (ptr_q)
      `CKGS_OFS_REF_MID: begin
        rd_data[`CKGS_BIT_REF_MID] = ref_mid_q;
      end
      `CKGS_OFS_MULTIPLIER: begin
        rd_data = i_third_loop_multiplier;
      end
      `CKGS_OFS_DIVIDER: begin
        rd_data = i_third_loop_divider;
      end
      `CKGS_OFS_SEL_STATUS: begin
        rd_data = sel_status_q;
      end
      `CKGS_OFS_MAKER_REV: begin
        rd_data = {MAKER_ID, REV_CODE};
      end
      `CKGS_OFS_PART_IDENT: begin
        rd_data = {PART_CODE, 4'h0};
      end
      `CKGS_OFS_SPARE_A: begin
        rd_data = `CKGS_RST_SPARE;
      end
      `CKGS_OFS_SPARE_B: begin
        rd_data = `CKGS_RST_SPARE;
      end
      `CKGS_OFS_LENGTH_COUNT: begin
        rd_data = length_count_q;
      end
      `CKGS_OFS_DRIVE_STRENGTH: begin
        rd_data = {ref_msb_q, ref_lsb_q, 6'h00};
      end
      default: begin
        rd_data = 8'h00;
      end
    endcase
  end

  // slave sequencing: sample on scl rise, drive on scl fall
  always @* begin
    state_d     = state_q;
    bitcnt_d    = bitcnt_q;
    ptr_d       = ptr_q;
    rw_d        = rw_q;
    block_d     = block_q;
    nack_d      = nack_q;
    oe_d        = o_smb_data_oe;
    wr_en       = 1'b0;
    tx_load     = 1'b0;
    tx_shift    = 1'b0;
    tx_load_val = rd_data;
    if (bus_start) begin
      state_d  = ST_ADDR;
      bitcnt_d = 4'h0;
      oe_d     = 1'b0;
    end else if (bus_stop) begin
      state_d  = ST_IDLE;
      bitcnt_d = 4'h0;
      oe_d     = 1'b0;
    end else if (state_q != ST_IDLE && state_q != ST_SKIP) begin
      if (scl_rise) begin
        if (bitcnt_q == `CKGS_BITS_PER_BYTE && state_q == ST_RDATA) begin
          nack_d = sda_s;
        end
        bitcnt_d = bitcnt_q + 4'h1;
      end else if (scl_fall) begin
        case (bitcnt_q)
          `CKGS_BITS_PER_BYTE: begin
            case (state_q)
              ST_ADDR: begin
                if (rx_byte[7:1] == SMB_ADDR) begin
                  oe_d = 1'b1;
                  rw_d = rx_byte[0];
                end else begin
                  state_d = ST_SKIP;
                end
              end
              ST_CMD: begin
                oe_d    = 1'b1;
                ptr_d   = rx_byte[4:0];
                block_d = ~rx_byte[`CKGS_BIT_CMD_BYTE_MODE];
              end
              ST_WCNT: begin
                oe_d = 1'b1;
              end
              ST_WDATA: begin
                oe_d  = 1'b1;
                wr_en = 1'b1;
                ptr_d = ptr_q + 5'h01;
              end
              default: begin
                oe_d = 1'b0;
              end
            endcase
          end
          `CKGS_ACK_SLOT: begin
            bitcnt_d = 4'h0;
            oe_d     = 1'b0;
            case (state_q)
              ST_ADDR: begin
                if (rw_q) begin
                  state_d = ST_RDATA;
                  tx_load = 1'b1;
                  if (block_q) begin
                    tx_load_val = length_count_q;
                  end else begin
                    ptr_d = ptr_q + 5'h01;
                  end
                  oe_d = ~tx_load_val[7];
                end else begin
                  state_d = ST_CMD;
                end
              end
              ST_CMD: begin
                state_d = block_q ? ST_WCNT : ST_WDATA;
              end
              ST_WCNT: begin
                state_d = ST_WDATA;
              end
              ST_RDATA: begin
                if (nack_q) begin
                  state_d = ST_SKIP;
                end else begin
                  tx_load = 1'b1;
                  ptr_d   = ptr_q + 5'h01;
                  oe_d    = ~rd_data[7];
                end
              end
              default: begin
                state_d = state_q;
              end
            endcase
          end
          default: begin
            if (state_q == ST_RDATA) begin
              if (bitcnt_q == 4'h0) begin
                oe_d = o_smb_data_oe;
              end else if (bitcnt_q < `CKGS_BITS_PER_BYTE) begin
                tx_shift = 1'b1;
                oe_d     = ~tx_byte[6];
              end
            end
          end
        endcase
        // release the line after the last data bit so the host can answer
        if (state_q == ST_RDATA && bitcnt_q == `CKGS_BITS_PER_BYTE) begin
          oe_d = 1'b0;
        end
      end
    end
  end

  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      scl_prev_q    <= 1'b1;
      sda_prev_q    <= 1'b1;
      state_q       <= ST_IDLE;
      bitcnt_q      <= 4'h0;
      ptr_q         <= 5'h00;
      rw_q          <= 1'b0;
      block_q       <= 1'b0;
      nack_q        <= 1'b0;
      o_smb_data_oe <= 1'b0;
      o_smb_data    <= 1'b0;
    end else begin
      scl_prev_q    <= scl_s;
      sda_prev_q    <= sda_s;
      state_q       <= state_d;
      bitcnt_q      <= bitcnt_d;
      ptr_q         <= ptr_d;
      rw_q          <= rw_d;
      block_q       <= block_d;
      nack_q        <= nack_d;
      o_smb_data_oe <= oe_d;
      o_smb_data    <= 1'b0;
    end
  end

  // status sampled each cycle; pcie enable pins are active low
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      sel_status_q <= 8'h00;
    end else begin
      sel_status_q <= {fsel_b_s, fsel_c_s, ~pcie_en_n_s, 3'h0};
    end
  end

  // writable bits; every other bit in these bytes drops the write
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ref_mid_q      <= `CKGS_RST_REF_MID;
      ref_msb_q      <= `CKGS_RST_REF_MSB;
      ref_lsb_q      <= `CKGS_RST_REF_LSB;
      length_count_q <= `CKGS_RST_LENGTH_COUNT;
    end else if (wr_en) begin
      case (ptr_q)
        `CKGS_OFS_REF_MID: begin
          ref_mid_q <= rx_byte[`CKGS_BIT_REF_MID];
        end
        `CKGS_OFS_LENGTH_COUNT: begin
          length_count_q <= rx_byte;
        end
        `CKGS_OFS_DRIVE_STRENGTH: begin
          ref_msb_q <= rx_byte[`CKGS_BIT_REF_MSB];
          ref_lsb_q <= rx_byte[`CKGS_BIT_REF_LSB];
        end
        default: begin
          ref_mid_q <= ref_mid_q;
        end
      endcase
    end
  end

  // control outputs come straight from flops
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_ref_drive_code        <= {`CKGS_RST_REF_MSB, `CKGS_RST_REF_MID,
                                  `CKGS_RST_REF_LSB};
      o_transfer_length_count <= `CKGS_RST_LENGTH_COUNT;
    end else begin
      o_ref_drive_code        <= {ref_msb_q, ref_mid_q, ref_lsb_q};
      o_transfer_length_count <= length_count_q;
    end
  end

endmodule // ckgs_status_regs

`default_nettype wire

// ===== tb/ckgs_checker_properties.sv
// port checker for the status, ident and drive-strength register bank
// assumes: bound to ckgs_status_regs, one clock domain on i_mclk
`timescale 1ns/1ps
`default_nettype none

module ckgs_checker (
  // clock and reset
  input wire logic       i_mclk,
  input wire logic       i_reset,
  // bus pins
  input wire logic       i_smb_clk,
  input wire logic       o_smb_data,
  input wire logic       o_smb_data_oe,
  // control outputs
  input wire logic [2:0] o_ref_drive_code,
  input wire logic [7:0] o_transfer_length_count
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  sequence released_s;
    $fell(i_reset);
  endsequence
  sequence ack_hold_s;
    o_smb_data_oe [*4];
  endsequence

  data_low_only_a: assert property (o_smb_data == 1'b0)
    else $error("data output value not zero");
  code_reset_a: assert property (released_s |->
    o_ref_drive_code == 3'b011) else $error("drive code reset wrong");
  count_reset_a: assert property (released_s |->
    o_transfer_length_count == 8'h16) else $error("count reset wrong");
  oe_rise_low_a: assert property ($rose(o_smb_data_oe) |->
    !i_smb_clk) else $error("data pulled while bus clock high");
  oe_fall_low_a: assert property ($fell(o_smb_data_oe) |->
    !i_smb_clk) else $error("data released while bus clock high");
  oe_hold_a: assert property ($rose(o_smb_data_oe) |=>
    ack_hold_s) else $error("pulled data not held");
  code_change_a: assert property ($changed(o_ref_drive_code) |->
    !i_smb_clk) else $error("drive code changed outside a write");
  count_change_a: assert property ($changed(o_transfer_length_count)
    |-> !i_smb_clk) else $error("count changed outside a write");
endmodule // ckgs_checker

bind ckgs_status_regs ckgs_checker u_chk (
  .i_mclk                  (i_mclk),
  .i_reset                 (i_reset),
  .i_smb_clk               (i_smb_clk),
  .o_smb_data              (o_smb_data),
  .o_smb_data_oe           (o_smb_data_oe),
  .o_ref_drive_code        (o_ref_drive_code),
  .o_transfer_length_count (o_transfer_length_count)
);

`default_nettype wire

// ===== tb/ckgs_host.sv
// behavioural serial management host driving the bus pins
// assumes: open-drain data line with pull-up, device pulls via its oe
`timescale 1ns/1ps
`default_nettype none

module ckgs_host (
  // clock
  input  wire logic i_mclk,
  // device pull-down enable
  input  wire logic i_sda_oe,
  // bus pins
  output logic      o_scl,
  output logic      o_sda
);
  logic drv;

  // wired-and with pull-up, so a released line reads high
  assign o_sda = drv & ~i_sda_oe;

  initial begin
    o_scl = 1'b1;
    drv   = 1'b1;
  end

  task w(input int n);
    repeat (n) @(negedge i_mclk);
  endtask

  // phases of 8 cycles leave room for the 2-cycle sync latency
  task start;
    w(3); drv = 1'b1; w(5); o_scl = 1'b1; w(8); drv = 1'b0; w(8);
    o_scl = 1'b0;
  endtask

  task stop;
    w(3); drv = 1'b0; w(5); o_scl = 1'b1; w(8); drv = 1'b1; w(8);
  endtask

  task bit_io(input logic b, output logic s);
    w(3); drv = b; w(5); o_scl = 1'b1; w(4); s = o_sda; w(4);
    o_scl = 1'b0;
  endtask

  // msb first, ninth slot samples the acknowledge
  task tx(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  task rx(input logic nack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(nack, s);
  endtask
endmodule // ckgs_host

`default_nettype wire

// ===== tb/ckgs_status_regs_tb.sv
// self-checking bench for the status register bank over the serial bus
// assumes: ckgs_host drives the pins, checker bound separately
`timescale 1ns/1ps
`default_nettype none

`define CKGS_CHK(nm, ex, gt) begin checks_done++; \
  if ((gt) !== (ex)) begin fail_count++; \
  $display("BAD %s exp %h got %h", nm, ex, gt); end end

module ckgs_status_regs_tb;
  localparam [3:0] M_ID = 4'h9; // arbitrary value
  localparam [3:0] R_ID = 4'h2; // arbitrary value
  localparam [3:0] P_ID = 4'h7; // arbitrary value
  logic       mclk, reset, scl, sda, oe, freq_select_b_status, freq_select_c_status, k;
  logic [7:0] mul, div, cnt, v;
  logic [2:0] pen_n, code;
  logic [7:0] ex [8:16];
  int         fail_count, checks_done;

  always #2 mclk = ~mclk;

  ckgs_status_regs #(.MAKER_ID(M_ID), .REV_CODE(R_ID), .PART_CODE(P_ID))
  DUT (
    .i_mclk(mclk), .i_reset(reset), .i_smb_clk(scl), .i_smb_data(sda),
    .o_smb_data(), .o_smb_data_oe(oe), .i_third_loop_multiplier(mul),
    .i_third_loop_divider(div), .i_freq_select_b(freq_select_b_status),
    .i_freq_select_c(freq_select_c_status), .i_pcie_enable_n(pen_n),
    .o_ref_drive_code(code), .o_transfer_length_count(cnt));

  ckgs_host h (.i_mclk(mclk), .i_sda_oe(oe), .o_scl(scl), .o_sda(sda));

  task test_done;
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task wr(input logic [4:0] a, input logic [7:0] d);
    h.start; h.tx(8'hD2, k); h.tx({3'b100, a}, k); h.tx(d, k); h.stop;
    `CKGS_CHK("wr ack", 1'b1, k)
  endtask

  task rd(input logic [4:0] a, input logic [7:0] e);
    h.start; h.tx(8'hD2, k); h.tx({3'b100, a}, k);
    h.start; h.tx(8'hD3, k); h.rx(1'b1, v); h.stop;
    `CKGS_CHK("rd ack", 1'b1, k)
    `CKGS_CHK("read", e, v)
  endtask

  task do_reset;
    @(negedge mclk) reset = 1'b1;
    repeat (16) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
  endtask

  initial begin
    // a bit under three times the span the scenarios below need
    #200000;
    fail_count++;
    test_done;
  end

  initial begin
    mclk = 1'b0; reset = 1'b1; mul = 8'hA5; div = 8'h3C;
    freq_select_b_status = 1'b1; freq_select_c_status = 1'b0; pen_n = 3'b110;
    fail_count = 0; checks_done = 0;
    ex = '{8'hA5, 8'h3C, 8'h88, {M_ID, R_ID}, {P_ID, 4'h0},
           8'h00, 8'h00, 8'h16, 8'h40};
    do_reset;
    `CKGS_CHK("code", 3'b011, code)
    `CKGS_CHK("count", 8'h16, cnt)
    for (int a = 8; a <= 16; a++) rd(a[4:0], ex[a]);
    // inputs flip so stale snapshots would show
    @(negedge mclk) begin freq_select_b_status = 1'b0; freq_select_c_status = 1'b1; pen_n = 3'b001; end
    mul = 8'h5A; div = 8'hC3;
    rd(5'h0A, 8'h70);
    rd(5'h08, 8'h5A);
    rd(5'h09, 8'hC3);
    wr(5'h08, 8'hFF);
    wr(5'h0B, 8'h00);
    wr(5'h0C, 8'hFF);
    wr(5'h0E, 8'hFF);
    rd(5'h08, 8'h5A);
    rd(5'h0B, ex[11]);
    rd(5'h0C, ex[12]);
    rd(5'h0E, 8'h00);
    wr(5'h0F, 8'h20);
    `CKGS_CHK("count", 8'h20, cnt)
    rd(5'h0F, 8'h20);
    wr(5'h10, 8'hFF);
    `CKGS_CHK("code", 3'b111, code)
    rd(5'h10, 8'hC0);
    wr(5'h03, 8'hEF);
    `CKGS_CHK("code", 3'b101, code)
    rd(5'h03, 8'h00);
    wr(5'h10, 8'h40);
    `CKGS_CHK("code", 3'b001, code)
    // block read: count byte first, then incrementing data
    h.start; h.tx(8'hD2, k); h.tx(8'h0B, k);
    h.start; h.tx(8'hD3, k); h.rx(1'b0, v);
    `CKGS_CHK("blk count", 8'h20, v)
    h.rx(1'b0, v);
    `CKGS_CHK("blk data", ex[11], v)
    h.rx(1'b1, v); h.stop;
    `CKGS_CHK("blk data", ex[12], v)
    // foreign address must not be acknowledged
    h.start; h.tx(8'hD4, k); h.stop;
    `CKGS_CHK("ack", 1'b0, k)
    // block write: count byte must be dropped, data lands at 0x0F, 0x10
    h.start;
    h.tx(8'hD2, k);
    h.tx(8'h0F, k);
    h.tx(8'h05, k);
    h.tx(8'h21, k);
    h.tx(8'hC0, k);
    h.stop;
    `CKGS_CHK("blk wr ack", 1'b1, k)
    `CKGS_CHK("blk wr count", 8'h21, cnt)
    `CKGS_CHK("blk wr code", 3'b101, code)
    do_reset;
    `CKGS_CHK("code", 3'b011, code)
    `CKGS_CHK("count", 8'h16, cnt)
    rd(5'h10, 8'h40);
    test_done;
  end
endmodule // ckgs_status_regs_tb

`default_nettype wire
